// File: rtl/kpi_defines.svh
// Purpose: Offsets, field positions, reset values for the pin interrupt unit
// Assumes: Byte address is four times the register index
// Notes: Definitions only
`ifndef KPI_DEFINES_SVH
`define KPI_DEFINES_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define KPI_IDX_CTRL 16'h003c
`define KPI_IDX_PIN_EN 16'h307c
`define KPI_IDX_POLARITY 16'h307d
`define KPI_ADDR_CTRL (`KPI_IDX_CTRL << 2)
`define KPI_ADDR_PIN_EN (`KPI_IDX_PIN_EN << 2)
`define KPI_ADDR_POLARITY (`KPI_IDX_POLARITY << 2)
`define KPI_ADDR_W 16

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define KPI_BIT_MODE 0
`define KPI_BIT_IE 1
`define KPI_BIT_ACK 2
`define KPI_BIT_FLAG 3

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define KPI_RST_CTRL 8'h00
`define KPI_RST_PIN_EN 8'h00
`define KPI_RST_POLARITY 8'h00
`define KPI_MAX_PINS 8

`endif

// File: rtl/kpi_pkg.sv
// Purpose: Shared types of the pin interrupt unit
// Assumes: Constants come from kpi_defines.svh
// Notes: Types only
package kpi_pkg;

  // AXI response codes
  typedef enum logic [1:0] {
    KPI_RESP_OKAY = 2'b00,
    KPI_RESP_SLVERR = 2'b10
  } kpi_resp_type;

  // Register selected by an address
  typedef enum logic [1:0] {
    KPI_SEL_NONE,
    KPI_SEL_CTRL,
    KPI_SEL_PIN_EN,
    KPI_SEL_POLARITY
  } kpi_sel_type;

endpackage : kpi_pkg

// File: rtl/kpi_sync.sv
// Purpose: Two-flop synchroniser for the pin inputs
// Assumes: Pins may change at any time
// Notes: First stage is read only by the second stage
module kpi_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import kpi_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } kpi_sync_state_type;

  kpi_sync_state_type s_q;
  kpi_sync_state_type s_d;

  // Next state of both stages
  always_comb begin
    s_d = s_q;
    s_d.stage1 = din;
    s_d.stage2 = s_q.stage1;
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.stage2;

endmodule : kpi_sync

// File: rtl/kpi_top.sv
// Purpose: Pin interrupt unit with AXI4-Lite register access
// Assumes: Single clock; srst synchronous active high
// Notes: Deep stop detection compares raw pins with held history
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`include "kpi_defines.svh"

module kpi_top #(
  parameter int NUM_PINS = `KPI_MAX_PINS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [`KPI_MAX_PINS-1:0] pin_in,
  input wire logic wait_mode,
  input wire logic deep_stop_mode,
  input wire logic debug_halt,
  output logic pin_irq,
  output logic wake_req,
  input wire logic [`KPI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output kpi_pkg::kpi_resp_type s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`KPI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output kpi_pkg::kpi_resp_type s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import kpi_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] pin_n_enable;
    logic [7:0] pin_n_polarity;
    logic edge_level_select;
    logic pin_irq_enable;
    logic pin_irq_flag;
    logic irq;
    logic wake;
    logic [7:0] history;
    logic aw_held;
    logic [`KPI_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    kpi_resp_type bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    kpi_resp_type rresp;
  } kpi_state_type;

  kpi_state_type s_q;
  kpi_state_type s_d;
  logic [7:0] pin_sync;
  logic [7:0] pin_mask;
  logic [7:0] run_hit;
  logic [7:0] stop_hit;
  logic detect;
  // Control reset byte, split into its fields by the state register
  localparam logic [7:0] CTRL_RESET = `KPI_RST_CTRL;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Address to register select
  function automatic kpi_sel_type kpi_decode(input logic [`KPI_ADDR_W-1:0] addr);
    kpi_sel_type sel;
    sel = KPI_SEL_NONE;
    if (addr == `KPI_ADDR_W'(`KPI_ADDR_CTRL)) begin
      sel = KPI_SEL_CTRL;
    end else if (addr == `KPI_ADDR_W'(`KPI_ADDR_PIN_EN)) begin
      sel = KPI_SEL_PIN_EN;
    end else if (addr == `KPI_ADDR_W'(`KPI_ADDR_POLARITY)) begin
      sel = KPI_SEL_POLARITY;
    end
    return sel;
  endfunction : kpi_decode

  // Per-pin hit from current level, prior level, polarity and mode
  function automatic logic [7:0] kpi_hit(
    input logic [7:0] now,
    input logic [7:0] prev,
    input logic [7:0] pol,
    input logic mode
  );
    logic [7:0] edges;
    logic [7:0] levels;
    edges = (pol & now & ~prev) | (~pol & ~now & prev);
    levels = (pol & now) | (~pol & ~now);
    return mode ? (edges | levels) : edges;
  endfunction : kpi_hit

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  // Synchronise pins
  kpi_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .din(pin_in),
    .dout(pin_sync)
  );

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  // Pins beyond NUM_PINS are never usable
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_mask[i] = (i < NUM_PINS);
    end
  end

  assign run_hit = kpi_hit(pin_sync, s_q.history, s_q.pin_n_polarity, s_q.edge_level_select);
  // Raw pins against held history; trades metastability margin for no sync latency
  assign stop_hit = kpi_hit(pin_in, s_q.history, s_q.pin_n_polarity, s_q.edge_level_select);
  assign detect = deep_stop_mode ?
    |(stop_hit & s_q.pin_n_enable & pin_mask) :
    |(run_hit & s_q.pin_n_enable & pin_mask);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    // History frozen in deep stop so the raw compare has a reference
    if (!deep_stop_mode) begin
      s_d.history = pin_sync;
    end

    // Write address and data, taken in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end

    // Response handshake
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Perform a write once both halves are held
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = KPI_RESP_OKAY;
      unique case (kpi_decode(s_q.aw_addr))
        KPI_SEL_CTRL: begin
          if (s_q.w_lane0) begin
            s_d.edge_level_select = s_q.w_data[`KPI_BIT_MODE];
            s_d.pin_irq_enable = s_q.w_data[`KPI_BIT_IE];
            if (s_q.w_data[`KPI_BIT_ACK]) begin
              s_d.pin_irq_flag = 1'b0;
            end
          end
        end
        KPI_SEL_PIN_EN: begin
          if (s_q.w_lane0) begin
            s_d.pin_n_enable = s_q.w_data & pin_mask;
          end
        end
        KPI_SEL_POLARITY: begin
          if (s_q.w_lane0) begin
            s_d.pin_n_polarity = s_q.w_data & pin_mask;
          end
        end
        KPI_SEL_NONE: begin
          s_d.bresp = KPI_RESP_SLVERR;
        end
      endcase
    end

    // Debug halt does not gate detection
    if (detect) begin
      s_d.pin_irq_flag = 1'b1;
    end

    s_d.irq = s_d.pin_irq_flag & s_d.pin_irq_enable;
    s_d.wake = s_d.irq & (wait_mode | deep_stop_mode);

    // Read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = KPI_RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      unique case (kpi_decode(s_axi_araddr))
        KPI_SEL_CTRL: begin
          // Acknowledge bit always reads zero
          s_d.rdata[`KPI_BIT_FLAG] = s_q.pin_irq_flag;
          s_d.rdata[`KPI_BIT_IE] = s_q.pin_irq_enable;
          s_d.rdata[`KPI_BIT_MODE] = s_q.edge_level_select;
        end
        KPI_SEL_PIN_EN: begin
          s_d.rdata[7:0] = s_q.pin_n_enable;
        end
        KPI_SEL_POLARITY: begin
          s_d.rdata[7:0] = s_q.pin_n_polarity;
        end
        KPI_SEL_NONE: begin
          s_d.rresp = KPI_RESP_SLVERR;
        end
      endcase
    end

    // Ready flags registered from next state so outputs stay flop-driven
    s_d.awready = !s_d.aw_held && !s_d.bvalid;
    s_d.wready = !s_d.w_held && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.pin_n_enable <= `KPI_RST_PIN_EN;
      s_q.pin_n_polarity <= `KPI_RST_POLARITY;
      // Control fields from the packed reset byte
      s_q.edge_level_select <= CTRL_RESET[`KPI_BIT_MODE];
      s_q.pin_irq_enable <= CTRL_RESET[`KPI_BIT_IE];
      s_q.pin_irq_flag <= CTRL_RESET[`KPI_BIT_FLAG];
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pin_irq = s_q.irq;
  assign wake_req = s_q.wake;
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // Debug halt has no effect on this unit
  logic unused_debug;
  assign unused_debug = debug_halt;

endmodule : kpi_top

// File: verification/kpi_switch_model.sv
// Purpose: External switches driving the pin inputs
// Assumes: Bench sets the wanted levels and a settling lag
// Notes: Lag of zero gives a prompt change
module kpi_switch_model (
  input wire logic clk,
  input wire logic [7:0] want,
  input wire logic [3:0] lag,
  output logic [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q = 4'h0;
  initial pins = 8'h00;
  // Contacts settle only after the lag has run out
  always @(posedge clk) begin
    if (want == pins) cnt_q <= 4'h0;
    else if (cnt_q >= lag) pins <= want;
    else cnt_q <= cnt_q + 4'h1;
  end
endmodule : kpi_switch_model

// File: verification/kpi_top_assertions.sv
// Purpose: Port-level checks of the pin interrupt unit
// Assumes: Bound to kpi_top; wake_req shares the edge of pin_irq
// Notes: Bus timing follows the slave's registered handshakes
module kpi_top_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic wait_mode,
  input wire logic deep_stop_mode,
  input wire logic pin_irq,
  input wire logic wake_req,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_reset_quiet: assert property (disable iff (1'h0) srst |=> !pin_irq && !wake_req)
    else $error("request active after reset");
  a_wake_needs_irq: assert property (wake_req |-> pin_irq && ($past(wait_mode) || $past(deep_stop_mode)))
    else $error("wake without request or low-power mode");
  a_wake_in_wait: assert property (pin_irq && $past(wait_mode) |-> wake_req)
    else $error("no wake from wait");
  a_wake_in_stop: assert property (pin_irq && $past(deep_stop_mode) |-> wake_req)
    else $error("no wake from deep stop");
  a_irq_holds: assert property ($fell(pin_irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("request dropped without a write");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  // Main scenarios reached
  c_wake_wait: cover property (wake_req && $past(wait_mode));
  c_wake_stop: cover property (wake_req && $past(deep_stop_mode));
  c_irq_drop: cover property ($fell(pin_irq));
  c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : kpi_top_checker

bind kpi_top kpi_top_checker i_kpi_top_checker (.clk(clk), .srst(srst), .wait_mode(wait_mode),
  .deep_stop_mode(deep_stop_mode), .pin_irq(pin_irq), .wake_req(wake_req),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata));

// File: verification/kpi_top_tb.sv
// Purpose: Self-checking bench of the pin interrupt unit
// Assumes: Registers reached over AXI4-Lite
// Notes: Seed fixed so every run repeats
`include "kpi_defines.svh"
module kpi_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import kpi_pkg::*;
  logic clk = 1'h0, srst = 1'h1, wait_mode = 1'h0, deep_stop_mode = 1'h0, debug_halt = 1'h0;
  logic [7:0] want = 8'hff, pin_in;
  logic [3:0] lag = 4'h0, wstrb = 4'hf;
  logic pin_irq, wake_req, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_rvalid;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  kpi_resp_type s_axi_bresp, s_axi_rresp, rr, br;
  logic [15:0] regs [3] = '{`KPI_ADDR_CTRL, `KPI_ADDR_PIN_EN, `KPI_ADDR_POLARITY};
  int n_fail = 0, checks_done = 0, seed = 16;

  // ----------------------------------------
  // Clock, design and switches
  // ----------------------------------------
  always #10 clk = ~clk;
  kpi_top i_kpi_top (.clk(clk), .srst(srst), .pin_in(pin_in), .wait_mode(wait_mode),
    .deep_stop_mode(deep_stop_mode), .debug_halt(debug_halt), .pin_irq(pin_irq),
    .wake_req(wake_req), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  kpi_switch_model i_kpi_switch_model (.clk(clk), .want(want), .lag(lag), .pins(pin_in));

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Expected control read: flag, acknowledge reads zero, enable, mode
  function automatic logic [31:0] exp_ctrl(input logic fl, input logic ie, input logic md);
    return {28'h0, fl, 1'h0, ie, md};
  endfunction : exp_ctrl

  // Both halves offered together, each released once taken
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    #1;
    while (s_axi_awvalid || s_axi_wvalid) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      #1;
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'h1);
    br = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : bus_wr

  task automatic bus_rd(input logic [15:0] a, output logic [31:0] d, output kpi_resp_type r);
    logic stall;
    stall = 1'($random(seed));
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= !stall;
    do @(posedge clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    // Late ready makes the slave hold its answer one cycle
    if (stall) @(posedge clk);
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : bus_rd

  // One pin event; idle level first so stale edges are acknowledged away
  task automatic trial(input int p, input logic pol, md, ie, input logic [7:0] en,
                       input logic [1:0] lp);
    logic fl;
    fl = en[p];
    want <= {8{~pol}};
    lag <= 4'h0;
    repeat (6) @(posedge clk);
    bus_wr(`KPI_ADDR_PIN_EN, en);
    bus_wr(`KPI_ADDR_POLARITY, {8{pol}});
    bus_wr(`KPI_ADDR_CTRL, {4'h0, 2'h3, ie, md});
    wait_mode <= lp[0];
    deep_stop_mode <= lp[1];
    want[p] <= pol;
    lag <= 4'($random(seed) & 7);
    repeat (20) @(posedge clk);
    chk("pin_irq", 32'(pin_irq), 32'(fl & ie));
    chk("wake_req", 32'(wake_req), 32'(fl & ie & |lp));
    bus_rd(`KPI_ADDR_CTRL, rd, rr);
    chk("ctrl", rd, exp_ctrl(fl, ie, md));
    chk("ctrl resp", 32'(rr), 32'(KPI_RESP_OKAY));
    wait_mode <= 1'h0;
    deep_stop_mode <= 1'h0;
    repeat (6) @(posedge clk);
    bus_wr(`KPI_ADDR_CTRL, {5'h0, 1'h1, ie, md});
    chk("ack resp", 32'(br), 32'(KPI_RESP_OKAY));
    repeat (4) @(posedge clk);
    chk("irq after ack", 32'(pin_irq), 32'(fl & ie & md));
    $display("trial pin %0d pol %0d mode %0d done", p, pol, md);
  endtask : trial

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    foreach (regs[i]) begin
      bus_rd(regs[i], rd, rr);
      chk("reset value", rd, 32'h0);
    end
    bus_rd(16'h0004, rd, rr);
    chk("unmapped resp", 32'(rr), 32'(KPI_RESP_SLVERR));
    bus_wr(16'h0004, 8'hff);
    chk("unmapped wresp", 32'(br), 32'(KPI_RESP_SLVERR));
    // Write without the lane 0 strobe must leave the enables alone
    wstrb <= 4'he;
    bus_wr(`KPI_ADDR_PIN_EN, 8'hff);
    chk("masked wresp", 32'(br), 32'(KPI_RESP_OKAY));
    wstrb <= 4'hf;
    bus_rd(`KPI_ADDR_PIN_EN, rd, rr);
    chk("masked write", rd, 32'h0);
    $display("bus response test done");
    for (int k = 0; k < 4; k++) trial(k * 2 + 1, k[0], k[1], 1'h1, 8'h01 << (k * 2 + 1), 2'h0);
    trial(0, 1'h0, 1'h1, 1'h1, 8'hfe, 2'h0);
    trial(4, 1'h1, 1'h0, 1'h0, 8'h10, 2'h0);
    trial(6, 1'h0, 1'h0, 1'h1, 8'h40, 2'h1);
    trial(2, 1'h1, 1'h1, 1'h1, 8'h04, 2'h2);
    // Random setups; debug halt must change nothing
    repeat (8) begin
      debug_halt <= 1'($random(seed));
      trial({$random(seed)} % 8, 1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
            8'($random(seed)), 2'({$random(seed)} % 3));
    end
    // Reset again mid-run: request and registers return to idle
    srst <= 1'h1;
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    chk("irq in reset", 32'(pin_irq), 32'h0);
    foreach (regs[i]) begin
      bus_rd(regs[i], rd, rr);
      chk("value after reset", rd, 32'h0);
    end
    $display("mid-run reset test done");
    results();
  end

  // Cuts a hang short well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end
endmodule : kpi_top_tb
